// [design/supply_sensor_pkg.sv]
// Purpose: Constants for the supply voltage sensor register block
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Offsets are byte addresses within the block
package supply_sensor_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_SENSE_ENABLE_SELECT = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_CONDITION_STATUS    = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE          = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_CHANGE_FLAGS        = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_TEST_RSVD0          = 3'h6;
    localparam logic [ADDR_W-1:0] OFS_TEST_RSVD1          = 3'h7;

    // Enable register fields
    localparam int unsigned BIT_SENSE_PIN_LEVEL_SENSE_EN = 0;
    localparam int unsigned BIT_SENSE_PIN_ADC_CONNECT    = 1;
    localparam int unsigned BIT_SUPPLY_LEVEL_SENSE_EN    = 2;
    localparam int unsigned BIT_SUPPLY_ADC_CONNECT       = 3;
    localparam int unsigned BIT_LOW_LEVEL_SELECT_LO      = 4;
    localparam int unsigned BIT_LOW_LEVEL_SELECT_HI      = 5;
    localparam int unsigned BIT_HIGH_LEVEL_SELECT        = 6;

    // Status, enable and flag fields
    localparam int unsigned BIT_LOW  = 0;
    localparam int unsigned BIT_HIGH = 1;

    // Reset values
    localparam logic [DATA_W-1:0] RST_ENABLE_SELECT = 8'h00;
    localparam logic [1:0]        RST_PAIR          = 2'h0;
    localparam logic [DATA_W-1:0] RST_TEST          = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO         = 8'h00;

    // Settling time of the analog path
    localparam int unsigned CLK_PERIOD_NS        = 10;
    localparam int unsigned ANALOG_SETTLE_TIME_NS = 1000;
    localparam int unsigned SETTLE_EXTRA_CYCLES  = 2;
    localparam int unsigned SETTLE_CYCLES =
        (ANALOG_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SETTLE_EXTRA_CYCLES;
    localparam int unsigned SETTLE_W = 8;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SETTLE = 2'b01
    } settle_state_t;

endpackage

// [design/supply_voltage_monitor_regs.sv]
// Purpose: Register, status and interrupt logic of the supply voltage sensor
// Assumes: Comparator outputs are asynchronous; bus inputs are synchronous to mclk
// Notes:   Analog divider, comparator and ADC sit outside this block
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ns

module supply_voltage_monitor_regs
    import supply_sensor_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              special_mode,
    input  wire logic              stop_mode,
    input  wire logic              cmp_high_async,
    input  wire logic              cmp_low_async,
    output logic                   battery_sense_path_en,
    output logic                   chip_supply_path_en,
    output logic                   battery_sense_compare_en,
    output logic                   chip_supply_compare_en,
    output logic                   battery_sense_adc_en,
    output logic                   chip_supply_adc_en,
    output logic                   high_level_select,
    output logic [1:0]             low_level_select,
    output logic [DATA_W-1:0]      test_reg0,
    output logic [DATA_W-1:0]      test_reg1,
    output logic                   result_valid,
    output logic                   module_irq
);

    // ************************************************************
    // Address decode
    // ************************************************************
    wire logic sel_enable = (addr == OFS_SENSE_ENABLE_SELECT);
    wire logic sel_status = (addr == OFS_CONDITION_STATUS);
    wire logic sel_irqen  = (addr == OFS_IRQ_ENABLE);
    wire logic sel_flags  = (addr == OFS_CHANGE_FLAGS);
    wire logic sel_test0  = (addr == OFS_TEST_RSVD0);
    wire logic sel_test1  = (addr == OFS_TEST_RSVD1);

    wire logic wr_enable = wr_en & sel_enable;
    wire logic wr_irqen  = wr_en & sel_irqen;
    wire logic wr_flags  = wr_en & sel_flags;
    wire logic wr_test0  = wr_en & sel_test0 & special_mode;
    wire logic wr_test1  = wr_en & sel_test1 & special_mode;

    // ************************************************************
    // Enable and select register
    // ************************************************************
    logic [DATA_W-1:0] enable_q;
    logic [DATA_W-1:0] enable_d;

    wire logic new_se_ls  = wdata[BIT_SENSE_PIN_LEVEL_SENSE_EN];
    wire logic new_se_adc = wdata[BIT_SENSE_PIN_ADC_CONNECT];
    // Supply bits lose to the sense pin bits, old or newly written
    wire logic new_su_ls  = wdata[BIT_SUPPLY_LEVEL_SENSE_EN] & ~new_se_ls
                            & ~enable_q[BIT_SENSE_PIN_LEVEL_SENSE_EN];
    wire logic new_su_adc = wdata[BIT_SUPPLY_ADC_CONNECT] & ~new_se_adc
                            & ~enable_q[BIT_SENSE_PIN_ADC_CONNECT];

    always_comb begin
        enable_d = enable_q;
        if (wr_enable) begin
            enable_d = READ_ZERO;
            enable_d[BIT_HIGH_LEVEL_SELECT]        = wdata[BIT_HIGH_LEVEL_SELECT];
            enable_d[BIT_LOW_LEVEL_SELECT_HI]      = wdata[BIT_LOW_LEVEL_SELECT_HI];
            enable_d[BIT_LOW_LEVEL_SELECT_LO]      = wdata[BIT_LOW_LEVEL_SELECT_LO];
            enable_d[BIT_SUPPLY_ADC_CONNECT]       = new_su_adc;
            enable_d[BIT_SUPPLY_LEVEL_SENSE_EN]    = new_su_ls;
            enable_d[BIT_SENSE_PIN_ADC_CONNECT]    = new_se_adc;
            enable_d[BIT_SENSE_PIN_LEVEL_SENSE_EN] = new_se_ls;
        end
    end

    // Stop mode does not touch configuration; analog path opens instead
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            enable_q <= RST_ENABLE_SELECT;
        end else begin
            enable_q <= enable_d;
        end
    end

    wire logic se_ls  = enable_q[BIT_SENSE_PIN_LEVEL_SENSE_EN];
    wire logic se_adc = enable_q[BIT_SENSE_PIN_ADC_CONNECT];
    wire logic su_ls  = enable_q[BIT_SUPPLY_LEVEL_SENSE_EN];
    wire logic su_adc = enable_q[BIT_SUPPLY_ADC_CONNECT];
    wire logic sense_on = (se_ls | su_ls) & ~stop_mode;

    assign high_level_select        = enable_q[BIT_HIGH_LEVEL_SELECT];
    assign low_level_select         = enable_q[BIT_LOW_LEVEL_SELECT_HI:BIT_LOW_LEVEL_SELECT_LO];
    assign battery_sense_compare_en = se_ls & ~stop_mode;
    assign chip_supply_compare_en   = su_ls & ~se_ls & ~stop_mode;
    assign battery_sense_adc_en     = se_adc & ~stop_mode;
    assign chip_supply_adc_en       = su_adc & ~se_adc & ~stop_mode;
    assign battery_sense_path_en    = (se_ls | se_adc) & ~stop_mode;
    assign chip_supply_path_en      = (su_ls | su_adc) & ~stop_mode;

    // ************************************************************
    // Settling window after an enable change
    // ************************************************************
    wire logic [3:0] path_bits = {su_adc, su_ls, se_adc, se_ls};
    wire logic [3:0] path_next = {enable_d[BIT_SUPPLY_ADC_CONNECT], enable_d[BIT_SUPPLY_LEVEL_SENSE_EN],
                                  enable_d[BIT_SENSE_PIN_ADC_CONNECT], enable_d[BIT_SENSE_PIN_LEVEL_SENSE_EN]};
    wire logic path_change = (path_next != path_bits);

    settle_state_t     settle_q;
    logic [SETTLE_W-1:0] settle_cnt_q;
    localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYCLES - 1);
    localparam logic [SETTLE_W-1:0] CNT_ZERO    = 8'h00;
    localparam logic [SETTLE_W-1:0] CNT_ONE     = 8'h01;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            settle_q     <= ST_IDLE;
            settle_cnt_q <= CNT_ZERO;
        end else begin
            case (settle_q)
                ST_IDLE: begin
                    if (path_change) begin
                        settle_q     <= ST_SETTLE;
                        settle_cnt_q <= SETTLE_LOAD;
                    end
                end
                ST_SETTLE: begin
                    if (path_change) begin
                        settle_cnt_q <= SETTLE_LOAD;
                    end else if (settle_cnt_q == CNT_ZERO) begin
                        settle_q <= ST_IDLE;
                    end else begin
                        settle_cnt_q <= settle_cnt_q - CNT_ONE;
                    end
                end
                default: begin
                    settle_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign result_valid = (settle_q == ST_IDLE);

    // ************************************************************
    // Comparator synchronisers and condition status
    // ************************************************************
    logic [1:0] cmp_meta_q;
    logic [1:0] cmp_sync_q;
    logic [1:0] cond_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cmp_meta_q <= RST_PAIR;
            cmp_sync_q <= RST_PAIR;
        end else begin
            cmp_meta_q <= {cmp_high_async, cmp_low_async};
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // Forced low when sensing is off, so disabling mid-condition raises a flag
    wire logic [1:0] cond_d = sense_on ? cmp_sync_q : RST_PAIR;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cond_q <= RST_PAIR;
        end else begin
            cond_q <= cond_d;
        end
    end

    wire logic [1:0] cond_change = cond_d ^ cond_q;

    // ************************************************************
    // Interrupt enables and change flags
    // ************************************************************
    logic [1:0] irqen_q;
    logic [1:0] flags_q;
    logic [1:0] flags_d;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_flag
            // Set beats a simultaneous write-one clear
            assign flags_d[gi] = cond_change[gi] |
                                 (flags_q[gi] & ~(wr_flags & wdata[gi]));
        end
    endgenerate

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irqen_q <= RST_PAIR;
            flags_q <= RST_PAIR;
        end else begin
            if (wr_irqen) begin
                irqen_q <= wdata[BIT_HIGH:BIT_LOW];
            end
            flags_q <= flags_d;
        end
    end

    // Gating by stop is left to the system; flags themselves survive
    assign module_irq = (flags_q[BIT_HIGH] & irqen_q[BIT_HIGH])
                      | (flags_q[BIT_LOW] & irqen_q[BIT_LOW]);

    // ************************************************************
    // Factory test registers
    // ************************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            test_reg0 <= RST_TEST;
            test_reg1 <= RST_TEST;
        end else begin
            if (wr_test0) begin
                test_reg0 <= wdata;
            end
            if (wr_test1) begin
                test_reg1 <= wdata;
            end
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    logic [DATA_W-1:0] rd_mux;

    // Status has no write path at all; unmapped reads give zero
    always_comb begin
        rd_mux = READ_ZERO;
        if (sel_enable) begin
            rd_mux = enable_q;
        end else if (sel_status) begin
            rd_mux[BIT_HIGH:BIT_LOW] = cond_q;
        end else if (sel_irqen) begin
            rd_mux[BIT_HIGH:BIT_LOW] = irqen_q;
        end else if (sel_flags) begin
            rd_mux[BIT_HIGH:BIT_LOW] = flags_q;
        end else if (sel_test0) begin
            rd_mux = test_reg0;
        end else if (sel_test1) begin
            rd_mux = test_reg1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata <= READ_ZERO;
        end else if (rd_en) begin
            rdata <= rd_mux;
        end else begin
            rdata <= READ_ZERO;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_supply_adc_excl: assert property (@(posedge mclk) disable iff (!resetn)
        !(se_adc && su_adc)) else $error("supply adc set beside sense adc");
    a_supply_ls_excl: assert property (@(posedge mclk) disable iff (!resetn)
        !(se_ls && su_ls)) else $error("supply sense set beside sense pin sense");
    a_adc_clears: assert property (@(posedge mclk) disable iff (!resetn)
        wr_enable && wdata[BIT_SENSE_PIN_ADC_CONNECT] |=> !su_adc) else $error("supply adc kept");
    a_ls_clears: assert property (@(posedge mclk) disable iff (!resetn)
        wr_enable && wdata[BIT_SENSE_PIN_LEVEL_SENSE_EN] |=> !su_ls) else $error("supply sense kept");
    a_settle_window: assert property (@(posedge mclk) disable iff (!resetn)
        path_change |=> !result_valid [*2]) else $error("result valid too soon");
    a_cond_forced: assert property (@(posedge mclk) disable iff (!resetn)
        !sense_on |=> cond_q == RST_PAIR) else $error("condition not forced low");
    a_flag_sets: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(cond_q[BIT_HIGH]) |-> flags_q[BIT_HIGH]) else $error("high flag missed");
    a_flag_low_sets: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(cond_q[BIT_LOW]) |-> flags_q[BIT_LOW]) else $error("low flag missed");
    a_flag_sticky: assert property (@(posedge mclk) disable iff (!resetn)
        flags_q[BIT_LOW] && !(wr_flags && wdata[BIT_LOW]) |=> flags_q[BIT_LOW]) else $error("flag lost");
    a_irq_combine: assert property (@(posedge mclk) disable iff (!resetn)
        module_irq == |(flags_q & irqen_q)) else $error("irq mismatch");
    a_sync_delay: assert property (@(posedge mclk) disable iff (!resetn)
        sense_on && $past(sense_on) && $past(sense_on, 2)
        |-> cond_q[BIT_LOW] == $past(cmp_low_async, 3)) else $error("sync depth wrong");
    a_test_guard: assert property (@(posedge mclk) disable iff (!resetn)
        wr_en && sel_test0 && !special_mode |=> $stable(test_reg0)) else $error("test write leaked");

    // ************************************************************
    // Shadow of the settle window
    // ************************************************************
    // Counts the window on its own, so an early or late release shows up
    logic [SETTLE_W-1:0] shadow_cnt_q;
    localparam logic [SETTLE_W-1:0] SHADOW_LOAD = SETTLE_W'(SETTLE_CYCLES);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            shadow_cnt_q <= CNT_ZERO;
        end else if (path_change) begin
            shadow_cnt_q <= SHADOW_LOAD;
        end else if (shadow_cnt_q != CNT_ZERO) begin
            shadow_cnt_q <= shadow_cnt_q - CNT_ONE;
        end
    end

    a_settle_length: assert property (@(posedge mclk) disable iff (!resetn)
        result_valid == (shadow_cnt_q == CNT_ZERO)) else $error("settle window length wrong");

    // ************************************************************
    // Bus, output routing, flag, interrupt and synchroniser checks
    // ************************************************************
    wire logic sel_none = ~(sel_enable | sel_status | sel_irqen | sel_flags | sel_test0 | sel_test1);

    a_high_select: assert property (@(posedge mclk) disable iff (!resetn)
        wr_enable |=> high_level_select == $past(wdata[BIT_HIGH_LEVEL_SELECT])) else $error("high select lost");
    a_low_select: assert property (@(posedge mclk) disable iff (!resetn)
        wr_enable |=> low_level_select == $past(wdata[BIT_LOW_LEVEL_SELECT_HI:BIT_LOW_LEVEL_SELECT_LO]))
        else $error("low select lost");
    a_adc_excl: assert property (@(posedge mclk) disable iff (!resetn)
        !(battery_sense_adc_en && chip_supply_adc_en)) else $error("both adc routes on");
    a_compare_excl: assert property (@(posedge mclk) disable iff (!resetn)
        !(battery_sense_compare_en && chip_supply_compare_en)) else $error("both compare sources on");
    a_compare_on: assert property (@(posedge mclk) disable iff (!resetn)
        sense_on == (battery_sense_compare_en || chip_supply_compare_en)) else $error("compare source wrong");
    a_status_high: assert property (@(posedge mclk) disable iff (!resetn)
        rd_en && sel_status |=> rdata[BIT_HIGH] == $past(cond_q[BIT_HIGH])) else $error("high status read wrong");
    a_status_low: assert property (@(posedge mclk) disable iff (!resetn)
        rd_en && sel_status |=> rdata[BIT_LOW] == $past(cond_q[BIT_LOW])) else $error("low status read wrong");
    a_status_ro: assert property (@(posedge mclk) disable iff (!resetn)
        wr_en && sel_status |=> $stable(enable_q) && $stable(irqen_q)) else $error("status write leaked");
    a_high_sticky: assert property (@(posedge mclk) disable iff (!resetn)
        flags_q[BIT_HIGH] && !(wr_flags && wdata[BIT_HIGH]) |=> flags_q[BIT_HIGH]) else $error("high flag lost");
    a_flag_clears: assert property (@(posedge mclk) disable iff (!resetn)
        wr_flags && wdata[BIT_LOW] && !cond_change[BIT_LOW] |=> !flags_q[BIT_LOW]) else $error("low flag kept");
    a_high_clears: assert property (@(posedge mclk) disable iff (!resetn)
        wr_flags && wdata[BIT_HIGH] && !cond_change[BIT_HIGH] |=> !flags_q[BIT_HIGH]) else $error("high flag kept");
    a_irq_high: assert property (@(posedge mclk) disable iff (!resetn)
        flags_q[BIT_HIGH] && irqen_q[BIT_HIGH] |-> module_irq) else $error("high request missing");
    a_irq_low: assert property (@(posedge mclk) disable iff (!resetn)
        flags_q[BIT_LOW] && irqen_q[BIT_LOW] |-> module_irq) else $error("low request missing");
    a_unmapped_zero: assert property (@(posedge mclk) disable iff (!resetn)
        rd_en && sel_none |=> rdata == READ_ZERO) else $error("unmapped read not zero");
    a_reg_pad: assert property (@(posedge mclk) disable iff (!resetn)
        rd_en && (sel_status || sel_irqen || sel_flags) |=> rdata[DATA_W-1:BIT_HIGH+1] == '0) else $error("pad bits set");
    a_enable_pad: assert property (@(posedge mclk) disable iff (!resetn)
        rd_en && sel_enable |=> !rdata[DATA_W-1]) else $error("enable top bit set");
    a_test1_guard: assert property (@(posedge mclk) disable iff (!resetn)
        wr_en && sel_test1 && !special_mode |=> $stable(test_reg1)) else $error("test write leaked");
    a_stop_keeps: assert property (@(posedge mclk) disable iff (!resetn)
        stop_mode && !wr_flags |=> (flags_q & $past(flags_q)) == $past(flags_q)) else $error("flag lost in stop");
    a_sync_high: assert property (@(posedge mclk) disable iff (!resetn)
        sense_on && $past(sense_on) && $past(sense_on, 2)
        |-> cond_q[BIT_HIGH] == $past(cmp_high_async, 3)) else $error("high sync depth wrong");

endmodule

// [test/analog_comparator_model.sv]
// Purpose: Behavioural analog comparator beside the sensor block
// Assumes: The bench gives the sensed voltage as an 8-bit code
// Notes:   Threshold codes are plain stand-ins; hysteresis is left out
`timescale 1ns/1ns
module analog_comparator_model #(
    parameter logic [7:0] HIGH1 = 8'hC8,
    parameter logic [7:0] HIGH2 = 8'hDC
) (
    input  wire logic [7:0] volt,
    input  wire logic       enable,
    input  wire logic       high_sel,
    input  wire logic [1:0] low_sel,
    output logic            cmp_high,
    output logic            cmp_low
);
    logic [7:0] high_thr;
    logic [7:0] low_thr;
    assign high_thr = high_sel ? HIGH2 : HIGH1;
    assign low_thr  = 8'h28 + {3'h0, low_sel, 3'h0};
    // Disabled comparator floats high on purpose: the block must mask it
    assign #3 cmp_high = enable ? (volt >= high_thr) : 1'b1;
    assign #3 cmp_low  = enable ? (volt < low_thr) : 1'b1;
endmodule

// [test/tb_supply_voltage_monitor_regs.sv]
// Purpose: Self-checking bench for the supply voltage sensor registers
// Assumes: Comparator model stands on the analog side
// Notes:   Random enable writes use a fixed seed
`timescale 1ns/1ns
module tb_supply_voltage_monitor_regs
    import supply_sensor_pkg::*;
;
    logic              mclk, resetn, wr_en, rd_en, special_mode, stop_mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, test_reg0, test_reg1;
    logic              cmp_high_async, cmp_low_async, high_level_select, result_valid, module_irq;
    logic              battery_sense_path_en, chip_supply_path_en, battery_sense_compare_en;
    logic              chip_supply_compare_en, battery_sense_adc_en, chip_supply_adc_en;
    logic [1:0]        low_level_select;
    logic [7:0]        volt, en_q, w, e;
    int                errors, samples_checked;

    supply_voltage_monitor_regs uut (.mclk, .resetn, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .special_mode, .stop_mode, .cmp_high_async, .cmp_low_async, .battery_sense_path_en,
        .chip_supply_path_en, .battery_sense_compare_en, .chip_supply_compare_en,
        .battery_sense_adc_en, .chip_supply_adc_en, .high_level_select, .low_level_select,
        .test_reg0, .test_reg1, .result_valid, .module_irq);

    analog_comparator_model cmp (.volt, .enable(battery_sense_compare_en | chip_supply_compare_en),
        .high_sel(high_level_select), .low_sel(low_level_select),
        .cmp_high(cmp_high_async), .cmp_low(cmp_low_async));

    // ****************
    // Tasks
    // ****************
    task automatic end_of_test;
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            errors++;
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task automatic pause;
        repeat (5) @(posedge mclk);
    endtask

    // Waits out the whole window after a sense or ADC path change
    task automatic settle;
        repeat (SETTLE_CYCLES) @(posedge mclk);
    endtask

    // Supply bits only stick while the sense-pin twin stays clear
    function automatic logic [7:0] next_en(input logic [7:0] old, input logic [7:0] d);
        next_en = d & 8'h73;
        if (d[3] && !d[1] && !old[1]) next_en[3] = 1'b1;
        if (d[2] && !d[0] && !old[0]) next_en[2] = 1'b1;
    endfunction

    // ****************
    // Sequence
    // ****************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #100000;
        errors++;
        end_of_test();
    end

    initial begin
        resetn = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        special_mode = 1'b0;
        stop_mode = 1'b0;
        volt = 8'h64;
        errors = 0;
        samples_checked = 0;
        en_q = 8'h00;
        void'($urandom(27));
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        for (int a = 0; a < 8; a++) rdchk(a[ADDR_W-1:0], 8'h00);
        // Voltage sits between all thresholds; flags raised while settling are cleared later
        for (int i = 0; i < 40; i++) begin
            w = 8'($urandom());
            if (i < 4) w = {1'b1, 7'h0F} ^ {4'h0, i[1:0], 2'h0};
            e = next_en(en_q, w);
            wr(OFS_SENSE_ENABLE_SELECT, w);
            rdchk(OFS_SENSE_ENABLE_SELECT, e);
            chk({high_level_select, low_level_select, battery_sense_compare_en, chip_supply_compare_en,
                 battery_sense_adc_en, chip_supply_adc_en, battery_sense_path_en},
                {e[6], e[5:4], e[0], e[2], e[1], e[3], e[0] | e[1]});
            chk({6'h00, chip_supply_path_en, chip_supply_compare_en}, {6'h00, e[2] | e[3], e[2]});
            en_q = e;
        end
        wr(3'h4, 8'hFF);
        rdchk(3'h4, 8'h00);
        // Interrupt enables stay clear while the path settles
        wr(OFS_SENSE_ENABLE_SELECT, 8'h01);
        settle();
        wr(OFS_CHANGE_FLAGS, 8'hFF);
        volt <= 8'hD0;
        pause();
        rdchk(OFS_CONDITION_STATUS, 8'h02);
        rdchk(OFS_CHANGE_FLAGS, 8'h02);
        chk({7'h00, module_irq}, 8'h00);
        wr(OFS_IRQ_ENABLE, 8'h02);
        #1 chk({7'h00, module_irq}, 8'h01);
        wr(OFS_CHANGE_FLAGS, 8'h01);
        rdchk(OFS_CHANGE_FLAGS, 8'h02);
        wr(OFS_CHANGE_FLAGS, 8'h02);
        rdchk(OFS_CHANGE_FLAGS, 8'h00);
        chk({7'h00, module_irq}, 8'h00);
        wr(OFS_SENSE_ENABLE_SELECT, 8'h41);
        pause();
        rdchk(OFS_CONDITION_STATUS, 8'h00);
        rdchk(OFS_CHANGE_FLAGS, 8'h02);
        wr(OFS_CHANGE_FLAGS, 8'h02);
        volt <= 8'h20;
        pause();
        rdchk(OFS_CONDITION_STATUS, 8'h01);
        rdchk(OFS_CHANGE_FLAGS, 8'h01);
        wr(OFS_IRQ_ENABLE, 8'h01);
        #1 chk({7'h00, module_irq}, 8'h01);
        wr(OFS_IRQ_ENABLE, 8'h00);
        #1 chk({7'h00, module_irq}, 8'h00);
        wr(OFS_CHANGE_FLAGS, 8'h01);
        wr(OFS_CONDITION_STATUS, 8'hFF);
        rdchk(OFS_CONDITION_STATUS, 8'h01);
        wr(OFS_SENSE_ENABLE_SELECT, 8'h00);
        #1 chk({7'h00, result_valid}, 8'h00);
        repeat (SETTLE_CYCLES - 1) @(posedge mclk);
        #1 chk({7'h00, result_valid}, 8'h00);
        @(posedge mclk);
        #1 chk({7'h00, result_valid}, 8'h01);
        rdchk(OFS_CONDITION_STATUS, 8'h00);
        rdchk(OFS_CHANGE_FLAGS, 8'h01);
        volt <= 8'h64;
        wr(OFS_SENSE_ENABLE_SELECT, 8'h03);
        settle();
        wr(OFS_CHANGE_FLAGS, 8'hFF);
        volt <= 8'h20;
        pause();
        stop_mode <= 1'b1;
        pause();
        chk({2'h0, battery_sense_path_en, battery_sense_compare_en, battery_sense_adc_en,
             chip_supply_path_en, chip_supply_compare_en, chip_supply_adc_en}, 8'h00);
        rdchk(OFS_SENSE_ENABLE_SELECT, 8'h03);
        rdchk(OFS_CHANGE_FLAGS, 8'h01);
        rdchk(OFS_CONDITION_STATUS, 8'h00);
        stop_mode <= 1'b0;
        rdchk(OFS_SENSE_ENABLE_SELECT, 8'h03);
        wr(OFS_TEST_RSVD0, 8'hA5);
        #1 chk(test_reg0, 8'h00);
        special_mode <= 1'b1;
        wr(OFS_TEST_RSVD1, 8'h5A);
        #1 chk(test_reg1, 8'h5A);
        rdchk(OFS_TEST_RSVD1, 8'h5A);
        special_mode <= 1'b0;
        end_of_test();
    end
endmodule
